/* File: rx_pkg.sv */
// Purpose: shared constants and config layout for the receive back end
// Assumes: both ends run their core logic at 100 MHz
// Notes: tick rates are oversample rates, bit rate times the oversample ratio
package rx_pkg;
   localparam int MCLK_HZ = 100_000_000; // core clock rate
   localparam longint BASE_TICK_HZ = 64'd4_874_880; // 152.34e3 times 32
   localparam longint KNX_TICK_HZ = 64'd1_048_576; // 32.768e3 times 32
   localparam int ACC_W = 24; // phase accumulator width
   localparam logic [ACC_W-1:0] BASE_INC = ACC_W'((BASE_TICK_HZ << ACC_W) / MCLK_HZ);
   localparam logic [ACC_W-1:0] KNX_INC = ACC_W'((KNX_TICK_HZ << ACC_W) / MCLK_HZ);
   localparam logic [7:0] OSR_DEFAULT = 8'h1f; // ratio 32, stored minus one
   localparam logic [7:0] OSR_MIN = 8'h0f; // smallest legal ratio field
   localparam int LEVEL_STEP_US = 100; // measurement interval step
   localparam int LEVEL_STEP_CYC = LEVEL_STEP_US * (MCLK_HZ / 1_000_000);
   localparam logic [3:0] REG_LEVEL = 4'h7; // level code register index
   localparam logic [3:0] REG_STATUS = 4'h8; // detect flag register index
   localparam logic [3:0] REG_FREQ = 4'hc; // frequency error register index
   localparam logic [1:0] LINE_A_LEVEL = 2'h1; // selector code for level irq
   localparam int CFG_HOLD = 8; // select low cycles per config transfer
   localparam int READ_HOLD = 8; // select low cycles per read transfer
   localparam int SYNC_W = 32; // stored sync word width
   localparam int MATCH_STEP = 8; // compare length step in bits
   localparam int FE_W = 16; // frequency error width

   // configuration word committed at the select rising edge
   typedef struct packed {
      logic bitsync_off;
      logic [6:0] rate_divisor;
      logic fixed_rate_select;
      logic osr_override_en;
      logic [7:0] oversample_ratio;
      logic match_en;
      logic [1:0] match_length;
      logic [1:0] match_tolerance;
      logic level_meter_en;
      logic level_range_sel;
      logic level_irq_en;
      logic [1:0] level_threshold;
      logic level_flag_clear; // write one clears the detect flag
      logic [1:0] line_a_source_sel;
      logic freq_err_en;
      logic [2:0] dev_band; // 0: above 20 kHz .. 4: at or below 5 kHz
      logic [SYNC_W-1:0] sync_word;
   } cfg_t;
endpackage

/* File: rx_link_if.sv */
// Purpose: wires between the receiver and the microcontroller end
// Assumes: line_b is the recovered clock and clocks the far capture logic
// Notes: the data pin is output only in continuous receive
interface rx_link_if;
   logic line_b; // recovered clock
   logic line_a; // level irq or match flag
   logic data_o; // recovered bit
   logic data_oe; // device drives data pin
   logic config_select_n; // low during a config transfer
   rx_pkg::cfg_t cfg_word; // config held stable by the host
   logic read_sel_n; // low during a read transfer
   logic [3:0] read_addr; // register index to read
   logic [rx_pkg::FE_W-1:0] read_data; // read answer
   modport dev (output line_b, line_a, data_o, data_oe, read_data,
      input config_select_n, cfg_word, read_sel_n, read_addr);
   modport host (input line_b, line_a, data_o, data_oe, read_data,
      output config_select_n, cfg_word, read_sel_n, read_addr);
endinterface

/* File: sync2.sv */
// Purpose: two flip-flop level synchroniser
// Assumes: input is a level that stays long enough to be seen
// Notes: the first stage feeds only the second
module sync2 #(
   parameter int W = 1
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_q; // first stage, read by q only

   // two stage capture
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         meta_q <= '0;
         q <= '0;
      end else if (ce) begin
         meta_q <= d;
         q <= meta_q;
      end
   end
endmodule

/* File: rx_backend.sv */
// Purpose: continuous mode receive back end, device end of the link
// Assumes: raw bit and comparator levels are asynchronous to mclk
// Notes: the recovered clock is divided from mclk, so one core domain here
// Operation
// - drive recovered clock and bit on pins
// - synchronizer on by default, recovers clock
// - data valid at recovered clock rising edge
// - synchronizer off: clock low, raw data
// - preamble first, then edges stay centred
// - bit rate from divisor field
// - fixed rate select forces 32.768 kbit/s
// - oversample 32 unless override field used
// - software keeps ratio at least 16
// - match enable compares stream to sync word
// - match flag changes on clock rising edges
// - length and tolerance fields shape matching
// - no match while synchronizer is off
// - level code from three thresholds
// - live level copied to register on read
// - measurement interval set by deviation band
// - level at threshold sets flag and irq
// - write one clears flag, comparison resumes
// - level irq on line a for code 01
// - frequency error loaded when register 12 read
// - config commits at select rising edge
// - frequency error signed, 500 Hz per step
// - line a irq or match, line b clock
module rx_backend #(
   parameter int LEVEL_STEP = rx_pkg::LEVEL_STEP_CYC
) (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire logic demod_bit,
   input wire logic [2:0] level_cmp,
   input wire logic [rx_pkg::FE_W-1:0] freq_meas,
   output logic level_irq,
   output logic match_flag,
   rx_link_if.dev link
);
   logic raw_s; // synced demodulator bit
   logic [2:0] cmp_s; // synced threshold comparisons
   logic sel_s; // synced config select, high while active
   logic rd_s; // synced read select, high while active
   logic sel_prev_q; // last select level
   logic rd_prev_q; // last read select level
   logic commit; // config select rising edge
   logic read_go; // read select falling edge
   rx_pkg::cfg_t cfg_q; // committed configuration
   logic [rx_pkg::ACC_W:0] acc_sum; // accumulator plus increment
   logic [rx_pkg::ACC_W-1:0] acc_q; // tick accumulator
   logic [6:0] pre_q; // divisor prescaler
   logic [6:0] div; // active divisor
   logic tick; // one oversample tick
   logic [7:0] osr; // active ratio minus one
   logic [7:0] half; // sample point in the bit
   logic [7:0] phase_q; // position in the bit
   logic [2:0] taps_q; // glitch filter taps
   logic filt; // majority of taps
   logic filt_prev_q; // last filtered level
   logic sample; // bit centre tick
   logic rise; // recovered clock rising tick
   logic dclk_q; // recovered clock
   logic data_q; // data pin value
   logic [rx_pkg::SYNC_W-1:0] shift_q; // recovered bit history
   logic [rx_pkg::SYNC_W-1:0] mask; // compared bit positions
   logic [5:0] errs; // mismatching bits
   logic match_q; // pattern match state
   logic [1:0] level_live; // latest measured level
   logic [1:0] level_code_q; // readable level code
   logic [18:0] meas_cnt_q; // measurement interval counter, as wide as the interval
   logic [18:0] meas_len; // interval length in cycles
   logic meas_go; // take a measurement now
   logic flag_q; // level detect flag
   logic fe_run_q; // frequency error block started
   logic [rx_pkg::FE_W-1:0] fe_q; // readable frequency error
   logic [rx_pkg::FE_W-1:0] rdata_q; // read answer

   // pin and other-domain inputs
   sync2 #(.W(1)) u_raw (.clk(mclk), .rst(rst), .ce(ce), .d(demod_bit), .q(raw_s));
   sync2 #(.W(3)) u_cmp (.clk(mclk), .rst(rst), .ce(ce), .d(level_cmp), .q(cmp_s));
   sync2 #(.W(1)) u_sel (.clk(mclk), .rst(rst), .ce(ce), .d(~link.config_select_n),
      .q(sel_s));
   sync2 #(.W(1)) u_rd (.clk(mclk), .rst(rst), .ce(ce), .d(~link.read_sel_n), .q(rd_s));

   // select edge detection, strobes synced active high so reset level is idle
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         sel_prev_q <= 1'b0;
         rd_prev_q <= 1'b0;
      end else if (ce) begin
         sel_prev_q <= sel_s;
         rd_prev_q <= rd_s;
      end
   end
   assign commit = ~sel_s & sel_prev_q;
   assign read_go = rd_s & ~rd_prev_q;

   // configuration commit, word is stable while select is high
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cfg_q <= '0; // bitsync_off resets to 0, synchronizer on
      end else if (ce && commit) begin
         cfg_q <= link.cfg_word;
      end
   end

   // oversample tick generator
   assign div = cfg_q.fixed_rate_select ? 7'h00 : cfg_q.rate_divisor;
   assign acc_sum = {1'b0, acc_q} + {1'b0, (cfg_q.fixed_rate_select ? rx_pkg::KNX_INC
      : rx_pkg::BASE_INC)};
   assign tick = acc_sum[rx_pkg::ACC_W] && (pre_q == div);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         acc_q <= '0;
         pre_q <= '0;
      end else if (ce) begin
         acc_q <= acc_sum[rx_pkg::ACC_W-1:0];
         // divide the base tick by divisor plus one
         if (acc_sum[rx_pkg::ACC_W]) begin
            pre_q <= (pre_q >= div) ? 7'h00 : pre_q + 7'h01;
         end
      end
   end

   // ratio selection, 32 unless overridden
   assign osr = cfg_q.osr_override_en ? cfg_q.oversample_ratio : rx_pkg::OSR_DEFAULT;
   assign half = osr >> 1;
   assign filt = (taps_q[0] & taps_q[1]) | (taps_q[1] & taps_q[2]) | (taps_q[0] & taps_q[2]);
   assign sample = tick && (phase_q == half);
   assign rise = tick && (phase_q == half + 8'h01) && (filt == filt_prev_q);

   // glitch filter and bit phase tracking
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         taps_q <= '0;
         filt_prev_q <= 1'b0;
         phase_q <= '0;
      end else if (ce && tick) begin
         taps_q <= {taps_q[1:0], raw_s};
         filt_prev_q <= filt;
         // a transition restarts the bit so the centre follows it
         if (filt != filt_prev_q) begin
            phase_q <= 8'h00;
         end else if (phase_q >= osr) begin
            phase_q <= 8'h00;
         end else begin
            phase_q <= phase_q + 8'h01;
         end
      end
   end

   // recovered clock: high in the second half of the bit
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         dclk_q <= 1'b0;
      end else if (ce) begin
         if (cfg_q.bitsync_off) begin
            dclk_q <= 1'b0;
         end else if (tick) begin
            dclk_q <= (phase_q > half) && (filt == filt_prev_q);
         end
      end
   end

   // data pin: set a tick before the clock rises
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_q <= 1'b0;
      end else if (ce) begin
         if (cfg_q.bitsync_off) begin
            data_q <= raw_s;
         end else if (sample) begin
            data_q <= filt;
         end
      end
   end

   // recovered bit history for the matcher
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         shift_q <= '0;
      end else if (ce && sample) begin
         shift_q <= {shift_q[rx_pkg::SYNC_W-2:0], filt};
      end
   end

   // count mismatches over the selected length
   always_comb begin
      mask = '0;
      errs = '0;
      for (int i = 0; i < rx_pkg::SYNC_W; i++) begin
         mask[i] = (i < (int'(cfg_q.match_length) + 1) * rx_pkg::MATCH_STEP);
         errs = errs + 6'(mask[i] & (shift_q[i] ^ cfg_q.sync_word[i]));
      end
   end

   // match flag, updated with the clock rising edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         match_q <= 1'b0;
      end else if (ce) begin
         if (cfg_q.bitsync_off || !cfg_q.match_en) begin
            match_q <= 1'b0;
         end else if (rise) begin
            match_q <= (errs <= {4'h0, cfg_q.match_tolerance});
         end
      end
   end

   // thermometer comparisons to two bit level
   always_comb begin
      level_live = 2'h0;
      if (cmp_s[2]) begin
         level_live = 2'h3;
      end else if (cmp_s[1]) begin
         level_live = 2'h2;
      end else if (cmp_s[0]) begin
         level_live = 2'h1;
      end
   end

   // measurement interval, one step per deviation band
   assign meas_len = 19'(LEVEL_STEP) * (19'(cfg_q.dev_band) + 19'h1);
   assign meas_go = cfg_q.level_meter_en && (meas_cnt_q + 19'h1 >= meas_len);
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         meas_cnt_q <= '0;
      end else if (ce) begin
         if (!cfg_q.level_meter_en || meas_go) begin
            meas_cnt_q <= '0;
         end else begin
            meas_cnt_q <= meas_cnt_q + 19'h1;
         end
      end
   end

   // level detect flag, a new detection beats the clear
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         flag_q <= 1'b0;
      end else if (ce) begin
         if (cfg_q.level_irq_en && cfg_q.level_meter_en && meas_go
            && (level_live >= cfg_q.level_threshold)) begin
            flag_q <= 1'b1;
         end else if (commit && link.cfg_word.level_flag_clear) begin
            flag_q <= 1'b0;
         end
      end
   end

   // frequency error block starts at commit
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fe_run_q <= 1'b0;
      end else if (ce && commit) begin
         fe_run_q <= link.cfg_word.freq_err_en;
      end
   end

   // snapshots taken when their register is read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         level_code_q <= '0;
         fe_q <= '0;
      end else if (ce && read_go) begin
         if (link.read_addr == rx_pkg::REG_LEVEL && cfg_q.level_meter_en) begin
            level_code_q <= level_live;
         end
         if (link.read_addr == rx_pkg::REG_FREQ && fe_run_q) begin
            fe_q <= freq_meas;
         end
      end
   end

   // read answer, one cycle after the snapshot
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rdata_q <= '0;
      end else if (ce) begin
         unique case (link.read_addr)
            rx_pkg::REG_LEVEL: rdata_q <= {14'h0, level_code_q};
            rx_pkg::REG_STATUS: rdata_q <= {15'h0, flag_q};
            rx_pkg::REG_FREQ: rdata_q <= fe_q;
            default: rdata_q <= '0;
         endcase
      end
   end

   // pins
   assign link.line_b = dclk_q;
   assign link.data_o = data_q;
   assign link.data_oe = 1'b1;
   assign link.line_a = (cfg_q.line_a_source_sel == rx_pkg::LINE_A_LEVEL) ? flag_q
      : match_q;
   assign link.read_data = rdata_q;
   assign level_irq = flag_q;
   assign match_flag = match_q;
endmodule

/* File: rx_mcu_end.sv */
// Purpose: microcontroller end: configures, reads, samples the stream
// Assumes: line_b may stop; the capture side needs no edge outside data
// Notes: captured bits cross to mclk with a toggle
module rx_mcu_end (
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   input wire rx_pkg::cfg_t cfg_in,
   input wire logic cfg_start,
   input wire logic read_start,
   input wire logic [3:0] read_addr_in,
   output logic busy,
   output logic [rx_pkg::FE_W-1:0] rd_data,
   output logic rd_done,
   output logic rx_bit,
   output logic rx_valid,
   output logic line_a_s,
   rx_link_if.host link
);
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_CFG = 2'b01,
      ST_READ = 2'b10
   } state_t;
   state_t state_q; // transfer state
   logic [3:0] cnt_q; // select low cycles
   rx_pkg::cfg_t word_q; // config word on the link
   logic [3:0] addr_q; // read index on the link
   logic [rx_pkg::FE_W-1:0] rd_s; // synced read answer
   logic bit_q; // bit taken at clock rise
   logic tgl_q; // flips once per captured bit
   logic tgl_s; // synced toggle
   logic tgl_prev_q; // last synced toggle

   // transfer sequencer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
         word_q <= '0;
         addr_q <= '0;
         rd_data <= '0;
         rd_done <= 1'b0;
      end else if (ce) begin
         rd_done <= 1'b0;
         unique case (state_q)
            ST_IDLE: begin
               cnt_q <= '0;
               if (cfg_start) begin
                  word_q <= cfg_in;
                  // keep the ratio legal
                  if (cfg_in.osr_override_en && cfg_in.oversample_ratio < rx_pkg::OSR_MIN) begin
                     word_q.oversample_ratio <= rx_pkg::OSR_MIN;
                  end
                  state_q <= ST_CFG;
               end else if (read_start) begin
                  addr_q <= read_addr_in;
                  state_q <= ST_READ;
               end
            end
            ST_CFG: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(rx_pkg::CFG_HOLD - 1)) begin
                  // word held until the next transfer, device commits it late
                  state_q <= ST_IDLE;
               end
            end
            ST_READ: begin
               cnt_q <= cnt_q + 4'h1;
               if (cnt_q == 4'(rx_pkg::READ_HOLD - 1)) begin
                  rd_data <= rd_s;
                  rd_done <= 1'b1;
                  state_q <= ST_IDLE;
               end
            end
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign busy = (state_q != ST_IDLE);
   assign link.config_select_n = (state_q != ST_CFG);
   assign link.read_sel_n = (state_q != ST_READ);
   assign link.cfg_word = word_q;
   assign link.read_addr = addr_q;

   sync2 #(.W(rx_pkg::FE_W)) u_rd (.clk(mclk), .rst(rst), .ce(ce), .d(link.read_data),
      .q(rd_s));
   sync2 #(.W(1)) u_la (.clk(mclk), .rst(rst), .ce(ce), .d(link.line_a), .q(line_a_s));

   // sample data on the recovered clock rising edge
   always_ff @(posedge link.line_b or posedge rst) begin
      if (rst) begin
         bit_q <= 1'b0;
         tgl_q <= 1'b0;
      end else begin
         bit_q <= link.data_o;
         tgl_q <= ~tgl_q;
      end
   end

   sync2 #(.W(1)) u_tg (.clk(mclk), .rst(rst), .ce(ce), .d(tgl_q), .q(tgl_s));

   // bit handover, bit_q is stable for a whole bit
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         tgl_prev_q <= 1'b0;
         rx_bit <= 1'b0;
         rx_valid <= 1'b0;
      end else if (ce) begin
         tgl_prev_q <= tgl_s;
         rx_valid <= tgl_s ^ tgl_prev_q;
         if (tgl_s ^ tgl_prev_q) begin
            rx_bit <= bit_q;
         end
      end
   end
endmodule

/* File: rx_link_chk.sv */
// Purpose: concurrent checks on the link wires between the two ends
// Assumes: every link wire is launched from mclk registers
// Notes: a config word takes effect a few cycles after select rises
module rx_link_chk (
   input wire logic mclk,
   input wire logic rst,
   input wire logic line_b,
   input wire logic line_a,
   input wire logic data_o,
   input wire logic data_oe,
   input wire logic config_select_n,
   input wire rx_pkg::cfg_t cfg_word,
   input wire logic read_sel_n,
   input wire logic [3:0] read_addr,
   input wire logic [rx_pkg::FE_W-1:0] read_data
);
   timeunit 1ns;
   timeprecision 1ps;
   // one domain, so one clock and one reset for all checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (rst);
   // end of a config transfer
   sequence cfg_end_s;
      $rose(config_select_n);
   endsequence
   // a wire held low for eight cycles
   sequence low_run_s(sig);
      (!sig) [*8];
   endsequence
   a_data_pin_out: assert property (data_oe)
      else $error("data pin not driven");
   a_clock_runs: assert property (
      cfg_end_s ##0 (!cfg_word.bitsync_off && cfg_word.rate_divisor == 7'h00
      && !cfg_word.fixed_rate_select && !cfg_word.osr_override_en) |-> ##[1:1000] line_b)
      else $error("recovered clock never rises");
   a_data_held_rise: assert property ($rose(line_b) |-> $stable(data_o))
      else $error("data moved at clock rise");
   a_clock_low_off: assert property (
      cfg_end_s ##0 cfg_word.bitsync_off |-> ##6 low_run_s(line_b))
      else $error("clock not low with synchronizer off");
   a_clock_high_half: assert property ($rose(line_b) |-> line_b [*8])
      else $error("clock high phase too short");
   a_no_match_off: assert property (
      cfg_end_s ##0 (cfg_word.bitsync_off && cfg_word.line_a_source_sel == 2'h0)
      |-> ##6 low_run_s(line_a))
      else $error("match reported with synchronizer off");
   a_match_on_edge: assert property (
      $changed(line_a) && cfg_word.match_en && !cfg_word.bitsync_off
      && cfg_word.line_a_source_sel != rx_pkg::LINE_A_LEVEL |-> line_b && !$past(line_b, 2))
      else $error("match flag moved off a clock rise");
   a_line_a_idle: assert property (
      cfg_end_s ##0 (!cfg_word.match_en && cfg_word.line_a_source_sel != rx_pkg::LINE_A_LEVEL)
      |-> ##6 low_run_s(line_a))
      else $error("line a high with matcher off");
   a_cfg_strobe_len: assert property (
      $fell(config_select_n) |-> low_run_s(config_select_n) ##1 config_select_n)
      else $error("config select length wrong");
   a_read_strobe_len: assert property (
      $fell(read_sel_n) |-> low_run_s(read_sel_n) ##1 read_sel_n)
      else $error("read select length wrong");
endmodule

/* File: tb_top.sv */
// Purpose: drives both ends of the receive link and checks the results
// Assumes: raw bits at divisor 0 last about 656 mclk cycles
// Notes: the level step is shortened to 20 cycles
module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int BIT = 656; // cycles per bit at divisor 0
   logic mclk = 1'b0; // core clock
   logic rst = 1'b1; // async reset
   logic demod_bit = 1'b0; // raw demodulator bit
   logic [2:0] level_cmp = 3'h0; // threshold comparisons
   logic [15:0] freq_meas = 16'(-5000 / 500); // error of minus 5 kHz
   rx_pkg::cfg_t cfg_in = '0; // word for the host end to send
   logic cfg_start = 1'b0;
   logic read_start = 1'b0;
   logic [3:0] read_addr_in = 4'h0;
   logic busy, rd_done, rx_bit, rx_valid, line_a_s, level_irq, match_flag;
   logic [15:0] rd_data;
   logic [8:0] rxsh = 9'h000; // captured bits, newest at bit 0
   logic seen = 1'b0; // match seen at the host
   int miscompares = 0;
   int checked = 0;
   int dv[4] = '{0, 1, 5, 0}; // divisor per rate case
   int p;
   longint e;
   rx_pkg::cfg_t c;
   // free running core clock
   always #5 mclk = ~mclk;
   rx_link_if link_inst ();
   rx_backend #(.LEVEL_STEP(20)) rx_backend_inst (.mclk(mclk), .rst(rst), .ce(1'b1),
      .demod_bit(demod_bit), .level_cmp(level_cmp), .freq_meas(freq_meas),
      .level_irq(level_irq), .match_flag(match_flag), .link(link_inst.dev));
   rx_mcu_end rx_mcu_end_inst (.mclk(mclk), .rst(rst), .ce(1'b1), .cfg_in(cfg_in),
      .cfg_start(cfg_start), .read_start(read_start), .read_addr_in(read_addr_in),
      .busy(busy), .rd_data(rd_data), .rd_done(rd_done), .rx_bit(rx_bit),
      .rx_valid(rx_valid), .line_a_s(line_a_s), .link(link_inst.host));
   rx_link_chk rx_link_chk_inst (.mclk(mclk), .rst(rst), .line_b(link_inst.line_b),
      .line_a(link_inst.line_a), .data_o(link_inst.data_o), .data_oe(link_inst.data_oe),
      .config_select_n(link_inst.config_select_n), .cfg_word(link_inst.cfg_word),
      .read_sel_n(link_inst.read_sel_n), .read_addr(link_inst.read_addr),
      .read_data(link_inst.read_data));
   // collect bits and note any match seen by the host
   always @(posedge mclk) begin
      if (rx_valid === 1'b1) rxsh <= {rxsh[7:0], rx_bit};
      if (line_a_s === 1'b1) seen <= 1'b1;
   end
   // one comparison, counted
   task automatic cmp(input logic [15:0] g, input logic [15:0] x, input string m);
      checked++;
      if (g !== x) begin
         miscompares++;
         $display("wrong value at %0t: %s got %h expected %h", $time, m, g, x);
      end
   endtask
   // one config transfer, then room for the commit
   task automatic cfg(input rx_pkg::cfg_t v);
      @(posedge mclk) #1;
      cfg_in = v;
      cfg_start = 1'b1;
      @(posedge mclk) #1;
      cfg_start = 1'b0;
      cmp({15'h0, busy}, 16'h0001, "busy in transfer");
      repeat (16) @(posedge mclk);
      #1;
   endtask
   // one read transfer compared with the expected word
   task automatic rc(input logic [3:0] a, input logic [15:0] x, input string m);
      int n;
      @(posedge mclk) #1;
      read_addr_in = a;
      read_start = 1'b1;
      @(posedge mclk) #1;
      read_start = 1'b0;
      n = 0;
      while (rd_done !== 1'b1 && n < 50) begin
         @(posedge mclk) #1;
         n++;
      end
      cmp(rd_data, x, m);
   endtask
   // raw bits, first sent from the top
   task automatic send(input logic [31:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) begin
         demod_bit = v[i];
         repeat (BIT) @(posedge mclk);
         #1;
      end
   endtask
   // cycles between two later rises of the recovered clock
   task automatic period(output int q);
      time t0;
      repeat (2) @(posedge link_inst.line_b);
      t0 = $time;
      @(posedge link_inst.line_b);
      q = int'(($time - t0) / 10);
   endtask
   task automatic tally_and_finish();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // watchdog against a hang
   initial begin
      repeat (100000) @(posedge mclk);
      miscompares++;
      tally_and_finish();
   end
   // main sequence of tests
   initial begin
      repeat (2) @(posedge mclk);
      #1 rst = 1'b0;
      rc(rx_pkg::REG_LEVEL, 16'h0000, "level after reset");
      rc(rx_pkg::REG_FREQ, 16'h0000, "freq error while off");
      $display("reset test done");
      // default, divisor 1, fixed rate over divisor 5, ratio override 16
      for (int i = 0; i < 4; i++) begin
         c = '0;
         c.rate_divisor = 7'(dv[i]);
         c.fixed_rate_select = (i == 2);
         c.osr_override_en = (i == 3);
         c.oversample_ratio = 8'h0f;
         cfg(c);
         period(p);
         e = ((i == 3 ? 16 : 32) * longint'(rx_pkg::MCLK_HZ) * (i == 2 ? 1 : dv[i] + 1))
            / (i == 2 ? rx_pkg::KNX_TICK_HZ : rx_pkg::BASE_TICK_HZ);
         cmp(16'(p > e + 2 || p + 2 < e), 16'h0000, "bit period");
      end
      $display("rate test done");
      c = '0;
      c.match_en = 1'b1;
      c.sync_word = 32'h0000_00b4;
      cfg(c);
      send(32'h0055_5555, 24);
      send(32'h0000_0168, 9);
      cmp({7'h00, rxsh}, 16'h0168, "received bits");
      cmp({15'h0000, seen}, 16'h0001, "exact match");
      seen = 1'b0;
      send(32'h0000_016a, 9);
      cmp({15'h0000, seen}, 16'h0000, "one error, no tolerance");
      c.match_tolerance = 2'h1;
      cfg(c);
      send(32'h0000_016a, 9);
      cmp({15'h0000, seen}, 16'h0001, "one error tolerated");
      c.match_length = 2'h1;
      c.sync_word = 32'h0000_a5b4;
      cfg(c);
      seen = 1'b0;
      send(32'h0000_016a, 9);
      cmp({15'h0000, seen}, 16'h0000, "sixteen bit compare");
      $display("match test done");
      c.bitsync_off = 1'b1;
      c.match_length = 2'h0;
      c.sync_word = 32'h0000_00b4;
      cfg(c);
      seen = 1'b0;
      for (int i = 8; i >= 0; i--) begin
         demod_bit = c.sync_word[i];
         repeat (BIT) @(posedge mclk);
         #1;
         cmp({14'h0, link_inst.line_b, link_inst.data_o}, {15'h0, demod_bit}, "raw");
         cmp({15'h0, match_flag}, 16'h0000, "match flag off");
      end
      cmp({15'h0000, seen}, 16'h0000, "no match when off");
      $display("raw path test done");
      c = '0;
      c.level_meter_en = 1'b1;
      c.level_irq_en = 1'b1;
      c.level_threshold = 2'h2;
      c.line_a_source_sel = rx_pkg::LINE_A_LEVEL;
      cfg(c);
      for (int i = 0; i < 4; i++) begin
         level_cmp = 3'((1 << i) - 1);
         repeat (60) @(posedge mclk);
         #1;
         rc(rx_pkg::REG_LEVEL, 16'(i), "level code");
         rc(rx_pkg::REG_STATUS, 16'(i >= 2), "detect flag");
         cmp({14'h0, line_a_s, level_irq}, 16'(i >= 2 ? 3 : 0), "level irq");
      end
      level_cmp = 3'h0;
      c.level_flag_clear = 1'b1;
      cfg(c);
      rc(rx_pkg::REG_STATUS, 16'h0000, "flag cleared");
      level_cmp = 3'h7;
      repeat (60) @(posedge mclk);
      rc(rx_pkg::REG_STATUS, 16'h0001, "flag raised again");
      $display("level test done");
      c = '0;
      c.freq_err_en = 1'b1;
      cfg(c);
      rc(rx_pkg::REG_FREQ, 16'(-5000 / 500), "freq error");
      freq_meas = 16'(1500 / 500);
      rc(rx_pkg::REG_FREQ, 16'(1500 / 500), "freq error reloaded");
      $display("freq test done");
      tally_and_finish();
   end
endmodule
